// file: src/daor_regs.svh
// Address map, geometry and field constants of the dual-access RAM
`ifndef DAOR_REGS_SVH
`define DAOR_REGS_SVH

`define DAOR_NCPU       3
`define DAOR_NBLK       8
`define DAOR_BLK_WORDS  4096
`define DAOR_CPU_HI     24'h000000
`define DAOR_CPU_LAST   24'h00ffff
`define DAOR_DMA_HI     16'h0001
`define DAOR_DMA_BASE   32'h0001_0000
`define DAOR_DMA_LAST   32'h0001_ffff
`define DAOR_MMR_BYTES  16'h00c0
`define DAOR_SLOTS      2'h2
`define DAOR_BLK_MSB    15
`define DAOR_BLK_LSB    13

`endif

// file: src/daor_pkg.sv
// Types shared by the dual-access RAM design
`default_nettype none
package daor_pkg;
	typedef logic [15:0] daor_word_t;
	typedef logic [31:0] daor_dword_t;
	typedef logic [23:0] daor_cpu_addr_t;
	typedef logic [31:0] daor_dma_addr_t;
	typedef logic [14:0] daor_widx_t;
	typedef logic [2:0]  daor_blk_t;
	typedef logic [1:0]  daor_slot_t;
	typedef logic [7:0]  daor_mmr_addr_t;
endpackage
`default_nettype wire

// file: src/daor_top.sv
// Dual-access on-chip RAM: eight two-slot blocks, CPU and DMA access
//
// Functional notes
// R1: CPU byte addresses 000000h to 00FFFFh decode as the RAM region.
// R2: Eight blocks of 4K 16-bit words, each block spanning 2000h bytes.
// R3: Each block completes two accesses per cycle, any read/write mix.
// R4: Program bus, data buses and DMA bus all reach the blocks.
// R5: DMA sees the RAM at 0001 0000h to 0001 FFFFh, CPU address plus 10000h.
// R6: First 192 bytes of block zero go to the register area, not RAM. DMA accesses there do not reach it: reads return zero, writes are dropped.
// R7: DMA makes at most one 32-bit transfer per cycle, independent of CPU.
// R8: Over two requesters on one block: grant two, stall the rest.
`include "daor_regs.svh"
`default_nettype none
module daor_top
	import daor_pkg::*;
(
	input  wire logic                              clk_i,
	input  wire logic                              arst_n_i,
	input  wire logic [`DAOR_NCPU-1:0]             cpu_req_i,
	input  wire logic [`DAOR_NCPU-1:0]             cpu_we_i,
	input  wire daor_pkg::daor_cpu_addr_t [`DAOR_NCPU-1:0] cpu_addr_i,
	input  wire daor_pkg::daor_word_t [`DAOR_NCPU-1:0]     cpu_wdata_i,
	output var  logic [`DAOR_NCPU-1:0]             cpu_ack_o,
	output var  daor_pkg::daor_word_t [`DAOR_NCPU-1:0]     cpu_rdata_o,
	input  wire logic                              dma_req_i,
	input  wire logic                              dma_we_i,
	input  wire daor_pkg::daor_dma_addr_t          dma_addr_i,
	input  wire daor_pkg::daor_dword_t             dma_wdata_i,
	output var  logic                              dma_ack_o,
	output var  daor_pkg::daor_dword_t             dma_rdata_o,
	output var  logic                              mmr_req_o,
	output var  logic                              mmr_we_o,
	output var  daor_pkg::daor_mmr_addr_t          mmr_addr_o,
	output var  daor_pkg::daor_word_t              mmr_wdata_o,
	input  wire daor_pkg::daor_word_t              mmr_rdata_i
);
	import daor_pkg::*;

	localparam int NWORDS = `DAOR_NBLK * `DAOR_BLK_WORDS;

	// Storage of all blocks; block number is the top three word-index bits
	daor_word_t            mem_r [0:NWORDS-1];                // see R2

	logic [`DAOR_NCPU-1:0] ack_r;
	daor_word_t            rdata_r [`DAOR_NCPU];
	logic                  dma_ack_r;
	daor_dword_t           dma_rdata_r;
	logic                  mmr_req_r;
	logic                  mmr_we_r;
	daor_mmr_addr_t        mmr_addr_r;
	daor_word_t            mmr_wdata_r;
	logic [`DAOR_NCPU-1:0] mmr_port_r;

	logic [`DAOR_NCPU-1:0] cpu_in;
	logic [`DAOR_NCPU-1:0] cpu_mmr;
	logic [`DAOR_NCPU-1:0] busy;
	daor_widx_t            cpu_widx [`DAOR_NCPU];
	daor_blk_t             cpu_blk [`DAOR_NCPU];
	logic [`DAOR_NCPU-1:0] take_ram;
	logic [`DAOR_NCPU-1:0] take_mmr;
	logic                  mmr_take;
	logic                  dma_in;
	logic                  dma_mmr;
	logic                  take_dma;
	daor_widx_t            dma_widx;
	daor_blk_t             dma_blk;
	daor_slot_t            used [`DAOR_NBLK];

	// Per-port decode
	genvar gp;
	generate
		for (gp = 0; gp < `DAOR_NCPU; gp++)
		begin : g_dec
			assign cpu_in[gp] = (cpu_addr_i[gp] <= `DAOR_CPU_LAST); // see R1
			assign cpu_mmr[gp] =
				(cpu_addr_i[gp][15:0] < `DAOR_MMR_BYTES);          // see R6
			assign cpu_widx[gp] = cpu_addr_i[gp][15:1];
			assign cpu_blk[gp] =
				cpu_addr_i[gp][`DAOR_BLK_MSB:`DAOR_BLK_LSB];       // see R2
			// A port waits for its answer before it can be taken again
			assign busy[gp] = ack_r[gp] | (mmr_req_r & mmr_port_r[gp]);
		end
	endgenerate

	// DMA window is the CPU window shifted up by 10000h
	assign dma_in = (dma_addr_i[31:16] == `DAOR_DMA_HI);             // see R5
	assign dma_mmr = dma_in && (dma_addr_i[15:0] < `DAOR_MMR_BYTES); // see R6
	assign dma_widx = {dma_addr_i[15:2], 1'b0};
	assign dma_blk = dma_addr_i[`DAOR_BLK_MSB:`DAOR_BLK_LSB];

	// Slot arbitration: DMA first, then CPU ports in index order
	always_comb
	begin
		for (int b = 0; b < `DAOR_NBLK; b++)
		begin
			used[b] = 2'h0;
		end
		take_ram = '0;
		take_mmr = '0;
		mmr_take = 1'b0;
		take_dma = 1'b0;
		// A 32-bit word pair fills both slots of its block
		if (dma_req_i && dma_in && !dma_ack_r)                      // see R7
		begin
			take_dma = 1'b1;                                         // see R4
			if (!dma_mmr)
			begin
				used[dma_blk] = `DAOR_SLOTS;                         // see R3
			end
		end
		for (int p = 0; p < `DAOR_NCPU; p++)
		begin
			if (cpu_req_i[p] && cpu_in[p] && !busy[p])
			begin
				if (cpu_mmr[p])
				begin
					// One register access per cycle; later ports wait
					if (!mmr_take)
					begin
						mmr_take = 1'b1;
						take_mmr[p] = 1'b1;                          // see R6
					end
				end
				else if (used[cpu_blk[p]] < `DAOR_SLOTS)             // see R8
				begin
					take_ram[p] = 1'b1;                              // see R4
					used[cpu_blk[p]] = used[cpu_blk[p]] + 2'h1;      // see R3
				end
			end
		end
	end

	// Writes; two CPU writes to one word leave the higher port's data
	always_ff @(posedge clk_i)
	begin
		for (int p = 0; p < `DAOR_NCPU; p++)
		begin
			if (take_ram[p] && cpu_we_i[p])
			begin
				mem_r[cpu_widx[p]] <= cpu_wdata_i[p];                // see R3
			end
		end
		if (take_dma && !dma_mmr && dma_we_i)
		begin
			mem_r[dma_widx] <= dma_wdata_i[15:0];                    // see R5
			mem_r[dma_widx | 15'h0001] <= dma_wdata_i[31:16];
		end
	end

	// Per-port answers: RAM one cycle after take, registers after two
	generate
		for (gp = 0; gp < `DAOR_NCPU; gp++)
		begin : g_ans
			always_ff @(posedge clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					ack_r[gp] <= 1'b0;
					rdata_r[gp] <= 16'h0000;
				end
				else
				begin
					ack_r[gp] <= take_ram[gp] |
						(mmr_req_r & mmr_port_r[gp]);
					if (take_ram[gp])
					begin
						rdata_r[gp] <= mem_r[cpu_widx[gp]];          // see R3
					end
					else if (mmr_req_r && mmr_port_r[gp])
					begin
						rdata_r[gp] <= mmr_rdata_i;                  // see R6
					end
				end
			end
			assign cpu_ack_o[gp] = ack_r[gp];
			assign cpu_rdata_o[gp] = rdata_r[gp];
		end
	endgenerate

	// DMA answer; the register window is not reachable from DMA
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			dma_ack_r <= 1'b0;
			dma_rdata_r <= 32'h0000_0000;
		end
		else
		begin
			dma_ack_r <= take_dma;                                   // see R7
			if (take_dma)
			begin
				dma_rdata_r <= dma_mmr ? 32'h0000_0000 :
					{mem_r[dma_widx | 15'h0001], mem_r[dma_widx]};   // see R5
			end
		end
	end

	// Register area request stage
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			mmr_req_r <= 1'b0;
			mmr_we_r <= 1'b0;
			mmr_addr_r <= 8'h00;
			mmr_wdata_r <= 16'h0000;
			mmr_port_r <= '0;
		end
		else
		begin
			mmr_req_r <= mmr_take;                                   // see R6
			mmr_port_r <= take_mmr;
			for (int p = 0; p < `DAOR_NCPU; p++)
			begin
				if (take_mmr[p])
				begin
					mmr_we_r <= cpu_we_i[p];
					mmr_addr_r <= cpu_addr_i[p][7:0];
					mmr_wdata_r <= cpu_wdata_i[p];
				end
			end
		end
	end

	assign dma_ack_o = dma_ack_r;
	assign dma_rdata_o = dma_rdata_r;
	assign mmr_req_o = mmr_req_r;
	assign mmr_we_o = mmr_we_r;
	assign mmr_addr_o = mmr_addr_r;
	assign mmr_wdata_o = mmr_wdata_r;

endmodule
`default_nettype wire

// file: sim/daor_mmr_model.sv
// Register area model answering accesses the RAM forwards to it
`default_nettype none
module daor_mmr_model (
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	output var  logic [15:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem_r [96];
	logic [15:0] last_r;
	// Idle bus shows the inverse of the last value, so stale samples fail
	assign rdata_o = req_i ? mem_r[addr_i[7:1]] : ~last_r;
	always_ff @(posedge clk_i)
	begin
		if (req_i && we_i)
			mem_r[addr_i[7:1]] <= wdata_i;
		last_r <= rdata_o;
	end
endmodule
`default_nettype wire

// file: sim/daor_assertions.sv
// Port checker for the dual-access RAM top
`default_nettype none
module daor_checker
	import daor_pkg::*;
(
	input wire logic                           clk_i,
	input wire logic                           arst_n_i,
	input wire logic [2:0]                     cpu_req_i,
	input wire logic [2:0]                     cpu_we_i,
	input wire daor_pkg::daor_cpu_addr_t [2:0] cpu_addr_i,
	input wire logic [2:0]                     cpu_ack_o,
	input wire daor_pkg::daor_word_t [2:0]     cpu_rdata_o,
	input wire logic                           dma_req_i,
	input wire daor_pkg::daor_dma_addr_t       dma_addr_i,
	input wire logic                           dma_ack_o,
	input wire logic                           mmr_req_o,
	input wire daor_pkg::daor_mmr_addr_t       mmr_addr_o,
	input wire daor_pkg::daor_word_t           mmr_rdata_i
);
	logic [2:0] ram;
	wire idle = !(|cpu_ack_o) && !mmr_req_o && !dma_req_i;
	wire m0 = cpu_req_i[0] && !cpu_ack_o[0] && !mmr_req_o
		&& cpu_addr_i[0] < 24'h0000c0;
	// Plain RAM word in the same block as port 0
	always_comb
		for (int p = 0; p < 3; p++)
			ram[p] = cpu_addr_i[p] >= 24'h0000c0
				&& cpu_addr_i[p] <= 24'h00ffff
				&& cpu_addr_i[p][15:13] == cpu_addr_i[0][15:13];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	AST_CPU_RANGE: assert property (
		cpu_req_i[0] && cpu_addr_i[0] > 24'h00ffff |=> !cpu_ack_o[0])
		else $error("ack outside ram range");
	AST_RAM_ACK: assert property (
		idle && cpu_req_i[0] && ram[0] |=> cpu_ack_o[0])
		else $error("ram access late");
	AST_TWO_SLOT: assert property (
		idle && &cpu_req_i && &ram |=> cpu_ack_o == 3'b011)
		else $error("block slots misgranted");
	AST_DMA_CPU: assert property (
		dma_req_i && !dma_ack_o && dma_addr_i[31:16] == 16'h0001
		&& cpu_req_i[0] && ram[0] && !cpu_ack_o[0] && !mmr_req_o
		&& cpu_addr_i[0][15:13] != dma_addr_i[15:13]
		|=> dma_ack_o && cpu_ack_o[0])
		else $error("dma and cpu not parallel");
	AST_DMA_RANGE: assert property (
		dma_req_i && dma_addr_i[31:16] != 16'h0001 |=> !dma_ack_o)
		else $error("dma ack outside window");
	AST_MMR_FWD: assert property (
		m0 |=> mmr_req_o && !cpu_ack_o[0]
			&& mmr_addr_o == $past(cpu_addr_i[0][7:0]))
		else $error("register access not forwarded");
	AST_MMR_DATA: assert property (
		m0 && !cpu_we_i[0] |=> ##1 cpu_ack_o[0]
			&& cpu_rdata_o[0] == $past(mmr_rdata_i))
		else $error("register read data wrong");
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the dual-access RAM top
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import daor_pkg::*;
	logic           clk_i = 0, arst_n_i = 0, dma_req_i = 0, dma_we_i = 0;
	logic           dma_ack_o, mmr_req_o, mmr_we_o;
	logic [2:0]     cpu_req_i = 0, cpu_we_i = 0, cpu_ack_o;
	logic [3:0]     first, seen;
	daor_cpu_addr_t [2:0] cpu_addr_i = 0;
	daor_word_t [2:0]     cpu_wdata_i = 0, cpu_rdata_o;
	daor_dma_addr_t dma_addr_i = 0;
	daor_dword_t    dma_wdata_i = 0, dma_rdata_o;
	daor_mmr_addr_t mmr_addr_o;
	daor_word_t     mmr_wdata_o, mmr_rdata_i;
	int             errors = 0, compares = 0, cyc = 0;
	daor_top u_dut (.*);
	daor_mmr_model u_mmr (.clk_i, .req_i(mmr_req_o), .we_i(mmr_we_o),
		.addr_i(mmr_addr_o), .wdata_i(mmr_wdata_o), .rdata_o(mmr_rdata_i));
	always #12.5 clk_i = ~clk_i;
	task automatic chk(input logic c);
		compares++;
		if (c !== 1'b1)
			$display("ERROR %0t: mismatch %0d", $time, ++errors);
	endtask
	task automatic set(input int p, input logic w, input daor_cpu_addr_t a,
		input daor_word_t d);
		cpu_we_i[p] = w;
		cpu_addr_i[p] = a;
		cpu_wdata_i[p] = d;
	endtask
	// Requests drop in their ack cycle, so a port is never taken twice
	task automatic run(input logic [3:0] m);
		@(negedge clk_i);
		{dma_req_i, cpu_req_i} = m;
		seen = 0;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_i);
			#1;
			if (i == 0)
				first = {dma_ack_o, cpu_ack_o};
			seen |= {dma_ack_o, cpu_ack_o};
			@(negedge clk_i);
			{dma_req_i, cpu_req_i} = i < 7 ? m & ~seen : 4'h0;
		end
	endtask
	task automatic s_blocks;
		for (int b = 0; b < 8; b++)
		begin
			daor_cpu_addr_t a;
			a = 24'(b) << 13;
			set(1, 1, a + 24'h1ffe, 16'h1230 + 16'(b));
			set(2, 1, a + 24'h0100, 16'h0ab0 + 16'(b));
			run(4'h6);
			chk(first === 4'h6);
			set(0, 0, a + 24'h1ffe, 0);
			set(1, 0, a + 24'h0100, 0);
			run(4'h3);
			chk(cpu_rdata_o[0] === 16'h1230 + 16'(b));
			chk(cpu_rdata_o[1] === 16'h0ab0 + 16'(b));
		end
		// All three ports on block 7: the third must wait one cycle
		set(2, 0, 24'h00e100, 0);
		run(4'h7);
		chk(first === 4'h3 && seen === 4'h7);
		chk(cpu_rdata_o[2] === 16'h0ab7);
	endtask
	task automatic s_dma;
		dma_we_i = 1;
		dma_addr_i = 32'h0001_6200;
		dma_wdata_i = 32'hbeef_cafe;
		run(4'h9);
		chk(first === 4'h9);
		set(0, 0, 24'h006200, 0);
		set(1, 0, 24'h006202, 0);
		run(4'h3);
		chk({cpu_rdata_o[1], cpu_rdata_o[0]} === 32'hbeef_cafe);
		dma_addr_i = 32'h0002_6200;
		set(0, 0, 24'h016200, 0);
		run(4'h9);
		chk(seen === 4'h0);
		set(0, 1, 24'h0000be, 16'h5a3c);
		run(4'h1);
		chk(first === 4'h0 && seen === 4'h1);
		set(0, 0, 24'h0000be, 0);
		run(4'h1);
		chk(cpu_rdata_o[0] === 16'h5a3c);
		dma_we_i = 0;
		dma_addr_i = 32'h0001_00be;
		run(4'h8);
		chk(dma_rdata_o === 32'h0);
		dma_addr_i = 32'h0001_6200;
		run(4'h8);
		chk(dma_rdata_o === 32'hbeef_cafe);
	endtask
	task automatic conclude;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk_i)
		if (++cyc == 2000)
		begin
			errors++;
			conclude;
		end
	initial
	begin
		repeat (20) @(posedge clk_i);
		@(negedge clk_i);
		arst_n_i = 1;
		s_blocks;
		s_dma;
		conclude;
	end
endmodule
bind daor_top daor_checker u_chk (.*);
`default_nettype wire
